// ### shared/dfirq_pkg.sv
// Constants for the deframer error, interrupt and sync-request control block
package dfirq_pkg;

  localparam int          ADDR_W     = 12;
  localparam int          DATA_W     = 8;
  localparam int          NUM_LANES  = 4;
  localparam int          NUM_ERR    = 3;
  localparam int          NUM_SYNC   = 4;
  localparam int          CNT_W      = 8;

  // Register addresses
  localparam logic [11:0] ADDR_ERR_BASE   = 12'h46D;
  localparam logic [11:0] ADDR_SYNC_BASE  = 12'h470;
  localparam logic [11:0] ADDR_TEST_CTRL  = 12'h477;
  localparam logic [11:0] ADDR_ILAS_LEN   = 12'h478;
  localparam logic [11:0] ADDR_VECTOR     = 12'h47A;
  localparam logic [11:0] ADDR_SYNC_MASK  = 12'h47B;
  localparam logic [11:0] ADDR_THRESH     = 12'h47C;

  // Flag and enable vector bit positions (shared layout)
  localparam int          DISPARITY_BIT    = 7;
  localparam int          INVALID_SYM_BIT  = 6;
  localparam int          STRAY_CTRL_BIT   = 5;
  localparam int          RSVD_VECTOR_BIT  = 4;
  localparam int          LANE_ALIGN_BIT   = 3;
  localparam int          CHECKSUM_BIT     = 2;
  localparam int          FRAME_LOCK_BIT   = 1;
  localparam int          SYMBOL_LOCK_BIT  = 0;

  // Control register bits
  localparam int          TEST_MODE_BIT    = 7;
  localparam int          THR_MASK_EN_BIT  = 3;
  localparam int          IRQ_CLR_BIT      = 7;
  localparam int          CNT_DIS_BIT      = 6;
  localparam int          CNT_RST_BIT      = 5;
  localparam int          LANE_SEL_LSB     = 0;
  localparam int          LANE_SEL_W       = 3;

  // Reset values, vector enable write mask and counter saturation value
  localparam logic [7:0]  TEST_CTRL_RST    = 8'h00;
  localparam logic [7:0]  ILAS_LEN_RST     = 8'h01;
  localparam logic [7:0]  IRQ_MASK_RST     = 8'h00;
  localparam logic [7:0]  SYNC_MASK_RST    = 8'h08;
  localparam logic [7:0]  THRESH_RST       = 8'hFF;
  localparam logic [7:0]  VECTOR_WR_MASK   = 8'hEF;
  localparam logic [7:0]  CNT_MAX          = 8'hFF;

endpackage

// ### verilog/dfirq_sticky.sv
// Per-lane sticky failure flags with a clear-all strobe
`timescale 1ns/1ps
module dfirq_sticky
  import dfirq_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         mclk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic         clr_i,
  output logic      [W-1:0] flag_o
);

  logic [W-1:0] flag_q;
  logic [W-1:0] flag_d;

  // Set beats clear so a failure in the clear cycle survives
  always_comb begin
    flag_d = set_i | (flag_q & {W{~clr_i}}); // [RQ15]
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  sticky_clear_a: assert property ((clr_i && set_i == '0) |=> flag_q == '0) // [RQ15]
    else $error("sticky flag not cleared");
  sticky_hold_a: assert property ((set_i != '0) |=> ((flag_q & $past(set_i)) == $past(set_i)))
    else $error("failure lost");

endmodule

// ### verilog/dfirq_err_counter.sv
// Saturating per-lane error counter with threshold flag
`timescale 1ns/1ps
module dfirq_err_counter
  import dfirq_pkg::*;
(
  input  wire logic             mclk_i,
  input  wire logic             srst_i,
  input  wire logic             err_i,
  input  wire logic             dis_i,
  input  wire logic             cnt_clr_i,
  input  wire logic             flag_clr_i,
  input  wire logic [CNT_W-1:0] limit_i,
  output logic                  reached_o
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             reached_q;
  logic             reached_d;

  always_comb begin
    cnt_d = cnt_q;
    if (cnt_clr_i) begin
      cnt_d = '0;
    end else if (err_i && !dis_i && cnt_q != CNT_MAX) begin
      cnt_d = cnt_q + 8'h01; // [RQ14]
    end
    // Re-asserts while the count stays at or past the limit
    reached_d = (cnt_q >= limit_i) | (reached_q & ~flag_clr_i); // [RQ14]
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_q     <= '0;
      reached_q <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      reached_q <= reached_d;
    end
  end

  assign reached_o = reached_q;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  limit_reach_a: assert property ((cnt_q >= limit_i) |=> reached_q) // [RQ14]
    else $error("threshold reached but flag low");
  count_step_a: assert property ((err_i && !dis_i && !cnt_clr_i && cnt_q < CNT_MAX)
                                 |=> cnt_q == $past(cnt_q) + 8'h01) // [RQ14]
    else $error("error not counted");

endmodule

// ### verilog/dfirq_ctrl.sv
// Deframer link error flags, interrupt mask and sync request control
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
// What this block does
// [RQ1] Test mode bit set makes the receiver accept alignment frames continuously.
// [RQ2] Software sets threshold mask enable whenever it uses sync-request mask bits.
// [RQ3] Alignment length register counts multiframes over four; resets to one; never zero.
// [RQ4] Flag bit 7 reads one once disparity count hits threshold on a lane.
// [RQ5] Flag bit 6 reads one once invalid-symbol count hits threshold on a lane.
// [RQ6] Flag bit 5 reads one once stray control count hits threshold on a lane.
// [RQ7] Flag bit 3 reads one on lane alignment failure; bit 4 reads zero.
// [RQ8] Flag bit 2 reads one on a bad configuration checksum on any lane.
// [RQ9] Flag bit 1 reads one on frame lock failure on any lane.
// [RQ10] Flag bit 0 reads one on symbol lock failure on any lane.
// [RQ11] Enabled count errors drive the active-low interrupt low.
// [RQ12] Enabled sync and checksum failures drive the active-low interrupt low.
// [RQ13] Disparity sync enable set makes threshold hits raise the sync request.
// [RQ14] Three error kinds are counted per lane and compared to the limit.
// [RQ15] Writing one to bit 7 of a per-lane register clears its interrupt, unless its error count still meets the limit.
// [RQ16] Flags and enables share one address; interrupt stays low while enabled flag set.
module dfirq_ctrl
  import dfirq_pkg::*;
(
  input  wire logic                 mclk_i,
  input  wire logic                 srst_i,
  input  wire logic [ADDR_W-1:0]    addr_i,
  input  wire logic [DATA_W-1:0]    wr_data_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [DATA_W-1:0]    rd_data_o,
  input  wire logic [NUM_LANES-1:0] disp_err_i,
  input  wire logic [NUM_LANES-1:0] nit_err_i,
  input  wire logic [NUM_LANES-1:0] ucc_err_i,
  input  wire logic [NUM_LANES-1:0] symbol_lock_fail_i,
  input  wire logic [NUM_LANES-1:0] frame_lock_fail_i,
  input  wire logic [NUM_LANES-1:0] checksum_fail_i,
  input  wire logic [NUM_LANES-1:0] lane_align_fail_i,
  output logic                      alignment_test_mode_o,
  output logic                      threshold_mask_en_o,
  output logic      [DATA_W-1:0]    alignment_multiframe_count_o,
  output logic                      irq_n_o,
  output logic                      sync_request_out_o
);

  // Register state
  logic [DATA_W-1:0]    test_ctrl_q;
  logic [DATA_W-1:0]    test_ctrl_d;
  logic [DATA_W-1:0]    alignment_length_reg_q;
  logic [DATA_W-1:0]    alignment_length_reg_d;
  logic [DATA_W-1:0]    irq_mask_q;
  logic [DATA_W-1:0]    irq_mask_d;
  logic [DATA_W-1:0]    sync_mask_q;
  logic [DATA_W-1:0]    sync_mask_d;
  logic [DATA_W-1:0]    error_count_limit_q;
  logic [DATA_W-1:0]    error_count_limit_d;
  logic [NUM_LANES-1:0] cnt_dis_q [NUM_ERR];
  logic [NUM_LANES-1:0] cnt_dis_d [NUM_ERR];

  // Status and outputs
  logic [DATA_W-1:0]    flag_q;
  logic [DATA_W-1:0]    flag_d;
  logic [DATA_W-1:0]    rd_data_q;
  logic [DATA_W-1:0]    rd_data_d;
  logic                 irq_n_q;
  logic                 irq_n_d;
  logic                 sync_req_q;
  logic                 sync_req_d;

  // Per-lane links to the counters and sticky flags
  logic [NUM_LANES-1:0] err_ev     [NUM_ERR];
  logic [NUM_LANES-1:0] reached    [NUM_ERR];
  logic [NUM_LANES-1:0] cnt_clr    [NUM_ERR];
  logic [NUM_LANES-1:0] flag_clr   [NUM_ERR];
  logic [NUM_LANES-1:0] sync_ev    [NUM_SYNC];
  logic [NUM_LANES-1:0] sync_fail  [NUM_SYNC];
  logic [NUM_SYNC-1:0]  sync_clr;
  logic [NUM_ERR-1:0]   err_any;
  logic [NUM_SYNC-1:0]  sync_any;

  assign err_ev[0]  = disp_err_i;
  assign err_ev[1]  = nit_err_i;
  assign err_ev[2]  = ucc_err_i;
  assign sync_ev[0] = symbol_lock_fail_i;
  assign sync_ev[1] = frame_lock_fail_i;
  assign sync_ev[2] = checksum_fail_i;
  assign sync_ev[3] = lane_align_fail_i;

  // Error counters: kind t sits at ADDR_ERR_BASE + t and vector bit 7 - t
  for (genvar t = 0; t < NUM_ERR; t++) begin : g_kind
    for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
      dfirq_err_counter u_cnt (
        .mclk_i     (mclk_i),
        .srst_i     (srst_i),
        .err_i      (err_ev[t][l]),
        .dis_i      (cnt_dis_q[t][l]),
        .cnt_clr_i  (cnt_clr[t][l]),
        .flag_clr_i (flag_clr[t][l]),
        .limit_i    (error_count_limit_q),
        .reached_o  (reached[t][l])
      ); // [RQ14]
    end
    assign err_any[t] = |reached[t];
  end

  // Sync failure flags: kind c sits at ADDR_SYNC_BASE + c and vector bit c
  for (genvar c = 0; c < NUM_SYNC; c++) begin : g_sync
    dfirq_sticky #(
      .W (NUM_LANES)
    ) u_sticky (
      .mclk_i (mclk_i),
      .srst_i (srst_i),
      .set_i  (sync_ev[c]),
      .clr_i  (sync_clr[c]),
      .flag_o (sync_fail[c])
    );
    assign sync_any[c] = |sync_fail[c];
  end

  // Per-lane strobes decoded from the lane field with bit 7 or bit 5; sync clears decoded from bit 7 alone, for all lanes
  always_comb begin
    for (int t = 0; t < NUM_ERR; t++) begin
      for (int l = 0; l < NUM_LANES; l++) begin
        cnt_clr[t][l]  = 1'b0;
        flag_clr[t][l] = 1'b0;
        cnt_dis_d[t][l] = cnt_dis_q[t][l];
        if (wr_i && addr_i == ADDR_ERR_BASE + 12'(t) &&
            wr_data_i[LANE_SEL_LSB +: LANE_SEL_W] == 3'(l)) begin
          flag_clr[t][l]  = wr_data_i[IRQ_CLR_BIT]; // [RQ15]
          cnt_clr[t][l]   = wr_data_i[CNT_RST_BIT];
          cnt_dis_d[t][l] = wr_data_i[CNT_DIS_BIT];
        end
      end
    end
    for (int c = 0; c < NUM_SYNC; c++) begin
      sync_clr[c] = wr_i && addr_i == ADDR_SYNC_BASE + 12'(c) &&
                    wr_data_i[IRQ_CLR_BIT]; // [RQ15]
    end
  end

  // Software-written control registers
  always_comb begin
    test_ctrl_d            = test_ctrl_q;
    alignment_length_reg_d = alignment_length_reg_q;
    irq_mask_d             = irq_mask_q;
    sync_mask_d            = sync_mask_q;
    error_count_limit_d    = error_count_limit_q;
    if (wr_i) begin
      unique case (addr_i)
        ADDR_TEST_CTRL: begin
          test_ctrl_d = wr_data_i; // [RQ1]
        end
        ADDR_ILAS_LEN: begin
          // Zero would stall alignment forever, so it is refused
          if (wr_data_i != 8'h00) begin
            alignment_length_reg_d = wr_data_i; // [RQ3]
          end
        end
        ADDR_VECTOR: begin
          irq_mask_d = wr_data_i & VECTOR_WR_MASK; // [RQ16]
        end
        ADDR_SYNC_MASK: begin
          sync_mask_d = wr_data_i;
        end
        ADDR_THRESH: begin
          error_count_limit_d = wr_data_i; // [RQ14]
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      test_ctrl_q            <= TEST_CTRL_RST;
      alignment_length_reg_q <= ILAS_LEN_RST;
      irq_mask_q             <= IRQ_MASK_RST;
      sync_mask_q            <= SYNC_MASK_RST;
      error_count_limit_q    <= THRESH_RST;
      for (int t = 0; t < NUM_ERR; t++) begin
        cnt_dis_q[t] <= '0;
      end
    end else begin
      test_ctrl_q            <= test_ctrl_d;
      alignment_length_reg_q <= alignment_length_reg_d;
      irq_mask_q             <= irq_mask_d;
      sync_mask_q            <= sync_mask_d;
      error_count_limit_q    <= error_count_limit_d;
      for (int t = 0; t < NUM_ERR; t++) begin
        cnt_dis_q[t] <= cnt_dis_d[t];
      end
    end
  end

  // Flag vector, interrupt and sync request
  logic disparity_error_flag;
  logic invalid_symbol_flag;
  logic stray_control_char_flag;
  logic lane_align_fail_flag;
  logic config_checksum_fail_flag;
  logic frame_lock_fail_flag;
  logic symbol_lock_fail_flag;

  always_comb begin
    disparity_error_flag      = err_any[0]; // [RQ4]
    invalid_symbol_flag       = err_any[1]; // [RQ5]
    stray_control_char_flag   = err_any[2]; // [RQ6]
    lane_align_fail_flag      = sync_any[3]; // [RQ7]
    config_checksum_fail_flag = sync_any[2]; // [RQ8]
    frame_lock_fail_flag      = sync_any[1]; // [RQ9]
    symbol_lock_fail_flag     = sync_any[0]; // [RQ10]
    flag_d                   = 8'h00;
    flag_d[DISPARITY_BIT]    = disparity_error_flag;
    flag_d[INVALID_SYM_BIT]  = invalid_symbol_flag;
    flag_d[STRAY_CTRL_BIT]   = stray_control_char_flag;
    flag_d[RSVD_VECTOR_BIT]  = 1'b0; // [RQ7]
    flag_d[LANE_ALIGN_BIT]   = lane_align_fail_flag;
    flag_d[CHECKSUM_BIT]     = config_checksum_fail_flag;
    flag_d[FRAME_LOCK_BIT]   = frame_lock_fail_flag;
    flag_d[SYMBOL_LOCK_BIT]  = symbol_lock_fail_flag;
    // Low as long as any enabled flag stays set
    irq_n_d = ~|(flag_d & irq_mask_q); // [RQ11] [RQ12] [RQ16]
    // Mask enable is software's duty; the request does not wait for it
    sync_req_d = |({disparity_error_flag, invalid_symbol_flag, stray_control_char_flag}
                   & sync_mask_q[DISPARITY_BIT:STRAY_CTRL_BIT]); // [RQ13]
  end

  // Read data valid only in the cycle after the strobe
  always_comb begin
    rd_data_d = 8'h00;
    if (rd_i) begin
      if (addr_i >= ADDR_ERR_BASE && addr_i < ADDR_ERR_BASE + 12'(NUM_ERR)) begin
        rd_data_d[NUM_LANES-1:0] = reached[2'(addr_i - ADDR_ERR_BASE)];
      end else if (addr_i >= ADDR_SYNC_BASE && addr_i < ADDR_SYNC_BASE + 12'(NUM_SYNC)) begin
        rd_data_d[NUM_LANES-1:0] = sync_fail[2'(addr_i - ADDR_SYNC_BASE)];
      end else begin
        unique case (addr_i)
          ADDR_TEST_CTRL: rd_data_d = test_ctrl_q;
          ADDR_ILAS_LEN:  rd_data_d = alignment_length_reg_q;
          ADDR_VECTOR:    rd_data_d = flag_q; // [RQ16]
          ADDR_SYNC_MASK: rd_data_d = sync_mask_q;
          ADDR_THRESH:    rd_data_d = error_count_limit_q;
          default:        rd_data_d = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      flag_q     <= 8'h00;
      rd_data_q  <= 8'h00;
      irq_n_q    <= 1'b1;
      sync_req_q <= 1'b0;
    end else begin
      flag_q     <= flag_d;
      rd_data_q  <= rd_data_d;
      irq_n_q    <= irq_n_d;
      sync_req_q <= sync_req_d;
    end
  end

  assign rd_data_o                    = rd_data_q;
  assign irq_n_o                      = irq_n_q;
  assign sync_request_out_o           = sync_req_q;
  assign alignment_test_mode_o        = test_ctrl_q[TEST_MODE_BIT]; // [RQ1]
  assign threshold_mask_en_o          = test_ctrl_q[THR_MASK_EN_BIT];
  assign alignment_multiframe_count_o = alignment_length_reg_q; // [RQ3]

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  test_mode_out_a: assert property ((wr_i && addr_i == ADDR_TEST_CTRL) // [RQ1]
      |=> alignment_test_mode_o == $past(wr_data_i[TEST_MODE_BIT]))
    else $error("test mode output not updated");
  len_zero_refused_a: assert property ((wr_i && addr_i == ADDR_ILAS_LEN && wr_data_i == 8'h00) // [RQ3]
      |=> $stable(alignment_multiframe_count_o) && alignment_multiframe_count_o != 8'h00)
    else $error("zero alignment length accepted");
  disp_flag_a: assert property (err_any[0] |=> flag_q[DISPARITY_BIT]) // [RQ4]
    else $error("disparity flag missing");
  invalid_symbol_flag_a: assert property (err_any[1] |=> flag_q[INVALID_SYM_BIT]) // [RQ5]
    else $error("invalid symbol flag missing");
  stray_control_char_flag_a: assert property (err_any[2] |=> flag_q[STRAY_CTRL_BIT]) // [RQ6]
    else $error("stray control flag missing");
  align_rsvd_a: assert property ((|lane_align_fail_i) |-> ##2 flag_q[LANE_ALIGN_BIT]
      && !flag_q[RSVD_VECTOR_BIT]) // [RQ7]
    else $error("lane alignment flag wrong");
  checksum_flag_a: assert property ((|checksum_fail_i) |-> ##2 flag_q[CHECKSUM_BIT]) // [RQ8]
    else $error("checksum flag missing");
  frame_flag_a: assert property ((|frame_lock_fail_i) |-> ##2 flag_q[FRAME_LOCK_BIT]) // [RQ9]
    else $error("frame lock flag missing");
  symbol_flag_a: assert property ((|symbol_lock_fail_i) |-> ##2 flag_q[SYMBOL_LOCK_BIT]) // [RQ10]
    else $error("symbol lock flag missing");
  irq_count_a: assert property ((flag_d[7:5] & irq_mask_q[7:5]) != 3'h0 |=> !irq_n_o) // [RQ11]
    else $error("count interrupt not driven low");
  irq_sync_a: assert property ((flag_d[3:0] & irq_mask_q[3:0]) != 4'h0 |=> !irq_n_o) // [RQ12]
    else $error("sync interrupt not driven low");
  sync_req_a: assert property ((sync_mask_q[DISPARITY_BIT] && err_any[0]) // [RQ13]
      |=> sync_request_out_o)
    else $error("sync request not raised");
  vector_read_a: assert property ((rd_i && addr_i == ADDR_VECTOR) // [RQ16]
      |=> rd_data_o == $past(flag_q))
    else $error("vector read does not return flags");
  irq_release_a: assert property ((flag_d & irq_mask_q) == 8'h00 |=> irq_n_o) // [RQ16]
    else $error("interrupt low with no enabled flag");

  disp_irq_c: cover property (irq_mask_q[DISPARITY_BIT] && err_any[0] ##1 !irq_n_o);
  sync_req_c: cover property (!sync_request_out_o ##1 sync_request_out_o);
  clear_c: cover property (!irq_n_o ##1 sync_clr != 4'h0 ##2 irq_n_o);

endmodule

// ### dv/dfirq_tx_model.sv
// Transmitter-side model raising per-lane link error and sync failure events
`timescale 1ns/1ps
module dfirq_tx_model
  import dfirq_pkg::*;
(
  input  wire logic                 mclk_i,
  output logic      [NUM_LANES-1:0] disp_err_o,
  output logic      [NUM_LANES-1:0] nit_err_o,
  output logic      [NUM_LANES-1:0] ucc_err_o,
  output logic      [NUM_LANES-1:0] sym_fail_o,
  output logic      [NUM_LANES-1:0] frm_fail_o,
  output logic      [NUM_LANES-1:0] chk_fail_o,
  output logic      [NUM_LANES-1:0] aln_fail_o
);
  // Kinds: 0 disparity, 1 invalid symbol, 2 stray control, 3..6 lock/checksum/align
  logic [NUM_LANES-1:0] ev_q [7];

  initial begin
    foreach (ev_q[k]) ev_q[k] = '0;
  end

  assign disp_err_o = ev_q[0];
  assign nit_err_o  = ev_q[1];
  assign ucc_err_o  = ev_q[2];
  assign sym_fail_o = ev_q[3];
  assign frm_fail_o = ev_q[4];
  assign chk_fail_o = ev_q[5];
  assign aln_fail_o = ev_q[6];

  // One-cycle event after an optional idle gap, so slow senders are covered too
  task automatic pulse(input int kind, input int lane, input int gap);
    repeat (gap) @(posedge mclk_i);
    @(posedge mclk_i);
    ev_q[kind][lane] <= 1'b1;
    @(posedge mclk_i);
    ev_q[kind] <= '0;
  endtask
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the deframer error, interrupt and sync control block
`timescale 1ns/1ps
`define CHK(name, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("Error %s expected %h seen %h", name, exp, got); \
    end \
  end
module tb_top;
  import dfirq_pkg::*;

  logic                 mclk_i;
  logic                 srst_i;
  logic [ADDR_W-1:0]    addr_i;
  logic [DATA_W-1:0]    wr_data_i;
  logic                 wr_i;
  logic                 rd_i;
  logic [DATA_W-1:0]    rd_data_o;
  logic [NUM_LANES-1:0] disp_err, nit_err, ucc_err, sym_fail, frm_fail, chk_fail, aln_fail;
  logic                 test_mode;
  logic                 thr_en;
  logic [DATA_W-1:0]    mf_count;
  logic                 irq_n_o;
  logic                 sync_req;
  int                   num_errors;
  int                   check_count;

  dfirq_tx_model i_dfirq_tx_model (
    .mclk_i(mclk_i), .disp_err_o(disp_err), .nit_err_o(nit_err), .ucc_err_o(ucc_err),
    .sym_fail_o(sym_fail), .frm_fail_o(frm_fail), .chk_fail_o(chk_fail),
    .aln_fail_o(aln_fail)
  );

  dfirq_ctrl i_dfirq_ctrl (
    .mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .disp_err_i(disp_err),
    .nit_err_i(nit_err), .ucc_err_i(ucc_err), .symbol_lock_fail_i(sym_fail),
    .frame_lock_fail_i(frm_fail), .checksum_fail_i(chk_fail),
    .lane_align_fail_i(aln_fail), .alignment_test_mode_o(test_mode),
    .threshold_mask_en_o(thr_en), .alignment_multiframe_count_o(mf_count),
    .irq_n_o(irq_n_o), .sync_request_out_o(sync_req)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // Strobe drops on the sampling edge, so the next access starts one edge later
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge mclk_i);
    wr_i      <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] e, input string n);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    @(posedge mclk_i);
    `CHK(n, e, rd_data_o)
  endtask

  task automatic t_reset();
    cyc(1);
    `CHK("irq_n", 1'b1, irq_n_o)
    `CHK("sync_req", 1'b0, sync_req)
    `CHK("mf_count", 8'h01, mf_count)
    rdc(ADDR_ILAS_LEN, 8'h01, "ilas_len");
    rdc(ADDR_THRESH, 8'hFF, "thresh");
    rdc(ADDR_VECTOR, 8'h00, "vector");
    rdc(ADDR_TEST_CTRL, 8'h00, "test_ctrl");
    rdc(ADDR_SYNC_MASK, 8'h08, "sync_mask_rst");
  endtask

  task automatic t_ctrl();
    wr(ADDR_TEST_CTRL, 8'h88);
    cyc(1);
    `CHK("test_mode_on", 1'b1, test_mode)
    `CHK("thr_en", 1'b1, thr_en)
    wr(ADDR_ILAS_LEN, 8'h00);
    rdc(ADDR_ILAS_LEN, 8'h01, "ilas_len_zero");
    wr(ADDR_ILAS_LEN, 8'hFF);
    cyc(1);
    `CHK("mf_count_max", 8'hFF, mf_count)
    wr(ADDR_TEST_CTRL, 8'h08);
    cyc(1);
    `CHK("test_mode_off", 1'b0, test_mode)
    rdc(12'h400, 8'h00, "unmapped");
  endtask

  // Count kinds one at a time: one pulse short of the limit, then at it
  task automatic t_count();
    logic [7:0] bit_m;
    wr(ADDR_THRESH, 8'h02);
    for (int k = 0; k < 3; k++) begin
      bit_m = 8'h80 >> k;
      wr(ADDR_VECTOR, 8'h00);
      i_dfirq_tx_model.pulse(k, k + 1, 0);
      cyc(5);
      rdc(ADDR_VECTOR, 8'h00, "below_limit");
      i_dfirq_tx_model.pulse(k, k + 1, 3);
      cyc(5);
      rdc(ADDR_VECTOR, bit_m, "count_flag");
      rdc(ADDR_ERR_BASE + 12'(k), 8'h01 << (k + 1), "lane_reached");
      `CHK("irq_masked", 1'b1, irq_n_o)
      wr(ADDR_VECTOR, bit_m);
      cyc(2);
      `CHK("irq_count", 1'b0, irq_n_o)
      rdc(ADDR_VECTOR, bit_m, "flag_kept");
      `CHK("irq_held", 1'b0, irq_n_o)
      // Counter first: a clear while the count still meets the limit is overruled
      wr(ADDR_ERR_BASE + 12'(k), 8'h20 | 8'(k + 1));
      wr(ADDR_ERR_BASE + 12'(k), 8'h80 | 8'(k + 1));
      cyc(4);
      `CHK("irq_count_clr", 1'b1, irq_n_o)
      rdc(ADDR_VECTOR, 8'h00, "count_clr");
    end
  endtask

  task automatic t_sync();
    logic [7:0] bit_m;
    for (int b = 0; b < 4; b++) begin
      bit_m = 8'h01 << b;
      wr(ADDR_VECTOR, bit_m);
      i_dfirq_tx_model.pulse(3 + b, b, 1);
      cyc(3);
      `CHK("irq_sync", 1'b0, irq_n_o)
      rdc(ADDR_VECTOR, bit_m, "sync_flag");
      rdc(ADDR_SYNC_BASE + 12'(b), 8'h01 << b, "lane_fail");
      wr(ADDR_SYNC_BASE + 12'(b), 8'h80);
      cyc(4);
      `CHK("irq_sync_clr", 1'b1, irq_n_o)
      rdc(ADDR_VECTOR, 8'h00, "sync_clr");
    end
  endtask

  // Sync request follows the disparity sync enable, not the interrupt enables
  task automatic t_syncreq();
    wr(ADDR_TEST_CTRL, 8'h08);
    wr(ADDR_VECTOR, 8'h00);
    wr(ADDR_SYNC_MASK, 8'h00);
    i_dfirq_tx_model.pulse(0, 3, 0);
    i_dfirq_tx_model.pulse(0, 3, 0);
    cyc(5);
    `CHK("sync_off", 1'b0, sync_req)
    wr(ADDR_SYNC_MASK, 8'h88);
    cyc(3);
    `CHK("sync_on", 1'b1, sync_req)
    `CHK("irq_off", 1'b1, irq_n_o)
    rdc(ADDR_SYNC_MASK, 8'h88, "sync_mask");
    wr(ADDR_ERR_BASE, 8'h23);
    wr(ADDR_ERR_BASE, 8'h83);
    cyc(4);
    `CHK("sync_clr", 1'b0, sync_req)
  endtask

  // Disabled counter ignores errors; a clear alone is overruled while the count holds
  task automatic t_disable();
    wr(ADDR_SYNC_MASK, 8'h48);
    wr(ADDR_ERR_BASE + 12'h001, 8'h40);
    i_dfirq_tx_model.pulse(1, 0, 0);
    i_dfirq_tx_model.pulse(1, 0, 0);
    cyc(5);
    rdc(ADDR_ERR_BASE + 12'h001, 8'h00, "cnt_disabled");
    `CHK("sync_nit_off", 1'b0, sync_req)
    wr(ADDR_ERR_BASE + 12'h001, 8'h00);
    i_dfirq_tx_model.pulse(1, 0, 0);
    i_dfirq_tx_model.pulse(1, 0, 0);
    cyc(5);
    rdc(ADDR_ERR_BASE + 12'h001, 8'h01, "cnt_enabled");
    `CHK("sync_nit_on", 1'b1, sync_req)
    wr(ADDR_ERR_BASE + 12'h001, 8'h80);
    cyc(3);
    rdc(ADDR_ERR_BASE + 12'h001, 8'h01, "clr_overruled");
    wr(ADDR_ERR_BASE + 12'h001, 8'h20);
    wr(ADDR_ERR_BASE + 12'h001, 8'h80);
    cyc(4);
    rdc(ADDR_ERR_BASE + 12'h001, 8'h00, "cnt_cleared");
    `CHK("sync_nit_clr", 1'b0, sync_req)
  endtask

  task automatic complete_run();
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  initial begin
    num_errors  = 0;
    check_count = 0;
    srst_i      = 1'b1;
    addr_i      = '0;
    wr_data_i   = '0;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    repeat (16) @(posedge mclk_i);
    srst_i <= 1'b0;
    t_reset();
    t_ctrl();
    t_count();
    t_sync();
    t_syncreq();
    t_disable();
    complete_run();
  end

  // Whole run is well under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    complete_run();
  end
endmodule
